/* wdt_pkg.sv */
// Register map, field positions and timing constants for the timers
// Function
// - The 24-bit presettable watchdog counts down once per 1 MHz tick.
// - The preset sets the watchdog period from one tick to about 16.8 s.
// - A control bit picks an interrupt or a card reset on watchdog expiry.
// - Once enabled for reset, the watchdog stays enabled until card reset.
// - A log bit tells start-up code if any reset since the log was last cleared came from the watchdog.
// - The count is readable at any time and expiry acts at terminal count.
package wdt_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_HZ = 1000000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned WDT_W = 24;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned NTMR = 3;
  localparam logic [11:0] OFS_WCTRL = 12'h000;
  localparam logic [11:0] OFS_WPRESET = 12'h004;
  localparam logic [11:0] OFS_WCOUNT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_TCTRL = 12'h010;
  localparam logic [11:0] OFS_TBASE = 12'h020;
  localparam logic [11:0] OFS_TSTEP = 12'h008;
  localparam logic [11:0] OFS_TCNT = 12'h004;
  localparam int unsigned WC_EN = 0;
  localparam int unsigned WC_RST = 1;
  localparam int unsigned WC_KICK = 2;
  localparam int unsigned ST_WIRQ = 0;
  localparam int unsigned ST_WLOG = 1;
  localparam int unsigned ST_TIRQ = 4;
  localparam int unsigned TC_EN = 0;
  localparam int unsigned TC_CASC = 3;
  localparam int unsigned RSTPULSE = 16;
  localparam logic [WDT_W-1:0] WDT_RST = 24'hffffff;
endpackage : wdt_pkg

/* wdt_tick_if.sv */
`timescale 1ns/100ps
// Interface carrying the microsecond tick between the timers and the divider
interface wdt_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : wdt_tick_if

/* wdt_tick_gen.sv */
`timescale 1ns/100ps
// Divider making a one-cycle 1 MHz tick from the system clock
module wdt_tick_gen #(
  parameter int unsigned DIV = wdt_pkg::TICK_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  wdt_tick_if.src tk
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } wdt_tg_s;
  wdt_tg_s st_r, st_nxt;
  localparam logic [7:0] LAST = 8'(DIV - 1);
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt == LAST);
    st_nxt.cnt = st_nxt.tick ? 8'h00 : st_r.cnt + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tk.tick = st_r.tick;
endmodule : wdt_tick_gen

/* wdt_timers.sv */
`timescale 1ns/100ps
// Watchdog and three system downcounters behind an APB slave
module wdt_timers (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdtIrq,
  output logic tmrIrq,
  output logic cardRstReq
);
  localparam int unsigned WW = wdt_pkg::WDT_W;
  localparam int unsigned TW = wdt_pkg::TMR_W;
  localparam int unsigned N = wdt_pkg::NTMR;

  typedef struct packed {
    logic wEn;
    logic wRstSel;
    logic wLock;
    logic [WW-1:0] wPreset;
    logic [WW-1:0] wCnt;
    logic wIrq;
    logic wLog;
    logic [4:0] rstCnt;
    logic [N-1:0] tEn;
    logic casc;
    logic [N-1:0][TW-1:0] tPre;
    logic [N-1:0][TW-1:0] tCnt;
    logic [N-1:0] tIrq;
    logic [31:0] rdata;
  } wdt_st_s;

  wdt_st_s st_r, st_nxt;
  wdt_tick_if tk ();

  wdt_tick_gen i_wdt_tick_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk)
  );

  logic wr, rdSetup, hit;
  logic [N-1:0] tEnd;
  logic [11:0] tOfs;
  int unsigned tIdx;
  logic tSel, tCntSel;
  logic wSet;
  logic [N-1:0] tSet;

  assign wr = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // End of count per timer, used for cascade stepping
  always_comb begin
    for (int i = 0; i < N; i++) begin
      tEnd[i] = st_r.tEn[i] && tk.tick && (st_r.tCnt[i] == '0);
    end
  end

  // Timer register window decode
  always_comb begin
    tOfs = paddr - wdt_pkg::OFS_TBASE;
    tIdx = 32'(tOfs[11:3]);
    tSel = (paddr >= wdt_pkg::OFS_TBASE) && (tIdx < N) && !paddr[1]
      && !paddr[0];
    tCntSel = tOfs[2];
  end

  always_comb begin
    hit = tSel || paddr == wdt_pkg::OFS_WCTRL
      || paddr == wdt_pkg::OFS_WPRESET || paddr == wdt_pkg::OFS_WCOUNT
      || paddr == wdt_pkg::OFS_STATUS || paddr == wdt_pkg::OFS_TCTRL;
  end
  assign pslverr = psel && penable && !hit;

  always_comb begin
    st_nxt = st_r;
    wSet = 1'b0;
    tSet = '0;
    // Watchdog counting
    if (st_r.wEn && tk.tick) begin
      if (st_r.wCnt == '0) begin
        st_nxt.wCnt = st_r.wPreset;
        if (st_r.wRstSel) begin
          st_nxt.rstCnt = 5'(wdt_pkg::RSTPULSE);
        end else begin
          st_nxt.wIrq = 1'b1;
          wSet = 1'b1;
        end
      end else begin
        st_nxt.wCnt = st_r.wCnt - 1'b1;
      end
    end
    // System timers
    for (int i = 0; i < N; i++) begin
      if (st_r.tEn[i] && tk.tick) begin
        if (i == 1 && st_r.casc) begin
          if (tEnd[0]) begin
            st_nxt.tCnt[i] = (st_r.tCnt[i] == '0) ? st_r.tPre[i]
              : st_r.tCnt[i] - 1'b1;
            if (st_r.tCnt[i] == '0) begin
              st_nxt.tIrq[i] = 1'b1;
              tSet[i] = 1'b1;
            end
          end
        end else if (st_r.tCnt[i] == '0) begin
          st_nxt.tCnt[i] = st_r.tPre[i];
          if (!(i == 0 && st_r.casc)) begin
            st_nxt.tIrq[i] = 1'b1;
            tSet[i] = 1'b1;
          end
        end else begin
          st_nxt.tCnt[i] = st_r.tCnt[i] - 1'b1;
        end
      end
    end
    if (st_r.rstCnt != '0) begin
      st_nxt.rstCnt = st_r.rstCnt - 1'b1;
    end
    // Register writes; a flag set in the same cycle survives the clear
    if (wr) begin
      unique case (1'b1)
        paddr == wdt_pkg::OFS_WCTRL: begin
          if (!st_r.wLock) begin
            st_nxt.wEn = pwdata[wdt_pkg::WC_EN];
            st_nxt.wRstSel = pwdata[wdt_pkg::WC_RST];
            st_nxt.wLock = pwdata[wdt_pkg::WC_EN] && pwdata[wdt_pkg::WC_RST];
            if (pwdata[wdt_pkg::WC_EN] && !st_r.wEn) begin
              st_nxt.wCnt = st_r.wPreset;
            end
          end
          if (pwdata[wdt_pkg::WC_KICK]) begin
            st_nxt.wCnt = st_r.wPreset;
          end
        end
        paddr == wdt_pkg::OFS_WPRESET: begin
          st_nxt.wPreset = pwdata[WW-1:0];
          if (!st_r.wEn) begin
            st_nxt.wCnt = pwdata[WW-1:0];
          end
        end
        paddr == wdt_pkg::OFS_STATUS: begin
          if (pwdata[wdt_pkg::ST_WIRQ]) begin
            st_nxt.wIrq = wSet;
          end
          if (pwdata[wdt_pkg::ST_WLOG]) begin
            st_nxt.wLog = 1'b0;
          end
          for (int i = 0; i < N; i++) begin
            if (pwdata[wdt_pkg::ST_TIRQ + i]) begin
              st_nxt.tIrq[i] = tSet[i];
            end
          end
        end
        paddr == wdt_pkg::OFS_TCTRL: begin
          st_nxt.tEn = pwdata[wdt_pkg::TC_EN +: N];
          st_nxt.casc = pwdata[wdt_pkg::TC_CASC];
        end
        tSel: begin
          if (!tCntSel) begin
            st_nxt.tPre[tIdx] = pwdata[TW-1:0];
          end
          st_nxt.tCnt[tIdx] = pwdata[TW-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured at the setup edge from the values the state
    // takes at that edge, so prdata comes from a flip-flop yet still shows
    // the access-cycle state with no wait state
    st_nxt.rdata = '0;
    if (rdSetup) begin
      unique case (1'b1)
        paddr == wdt_pkg::OFS_WCTRL:
          st_nxt.rdata = {29'h0, st_nxt.wLock, st_nxt.wRstSel, st_nxt.wEn};
        paddr == wdt_pkg::OFS_WPRESET: st_nxt.rdata = 32'(st_nxt.wPreset);
        paddr == wdt_pkg::OFS_WCOUNT:
          st_nxt.rdata = 32'(st_nxt.wCnt);
        paddr == wdt_pkg::OFS_STATUS: begin
          st_nxt.rdata[wdt_pkg::ST_WIRQ] = st_nxt.wIrq;
          st_nxt.rdata[wdt_pkg::ST_WLOG] = st_nxt.wLog;
          st_nxt.rdata[wdt_pkg::ST_TIRQ +: N] = st_nxt.tIrq;
        end
        paddr == wdt_pkg::OFS_TCTRL: begin
          st_nxt.rdata[wdt_pkg::TC_EN +: N] = st_nxt.tEn;
          st_nxt.rdata[wdt_pkg::TC_CASC] = st_nxt.casc;
        end
        tSel: st_nxt.rdata = tCntSel ? 32'(st_nxt.tCnt[tIdx])
          : 32'(st_nxt.tPre[tIdx]);
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  assign prdata = st_r.rdata;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.wPreset <= wdt_pkg::WDT_RST;
      st_r.wCnt <= wdt_pkg::WDT_RST;
      // Log is set by the card reset if it was our own pulse; a log already set survives any reset
      st_r.wLog <= (st_r.rstCnt != '0) || st_r.wLog;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The card reset request is expected to loop back into rst_n
  assign cardRstReq = (st_r.rstCnt != '0);
  assign wdtIrq = st_r.wIrq;
  assign tmrIrq = |st_r.tIrq;
endmodule : wdt_timers

/* wdt_timers_sva.sv */
`timescale 1ns/100ps
// Port checker for the watchdog and system timer block
module wdt_timers_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdtIrq,
  input wire logic tmrIrq,
  input wire logic cardRstReq
);
  logic acc;
  logic stWr;
  logic lockR;
  assign acc = psel && penable;
  assign stWr = acc && pwrite && paddr == wdt_pkg::OFS_STATUS;
  // Remembers a reset-mode enable so later disable attempts can be judged
  always_ff @(posedge mclk) begin
    if (!rst_n) lockR <= 1'b0;
    else if (acc && pwrite && paddr == wdt_pkg::OFS_WCTRL
      && pwdata[1:0] == 2'b11)
      lockR <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    acc && paddr >= 12'h038 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok;
    acc && paddr <= wdt_pkg::OFS_TCTRL && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_wirq; wdtIrq && !stWr |=> wdtIrq; endproperty
  a_wirq: assert property (p_wirq) else $error("wdtIrq dropped");
  property p_tirq; tmrIrq && !stWr |=> tmrIrq; endproperty
  a_tirq: assert property (p_tirq) else $error("tmrIrq dropped");
  property p_stat;
    acc && !pwrite && paddr == wdt_pkg::OFS_STATUS |->
      prdata[0] == wdtIrq && (|prdata[6:4]) == tmrIrq;
  endproperty
  a_stat: assert property (p_stat) else $error("status mismatch");
  property p_lock;
    lockR && acc && !pwrite && paddr == wdt_pkg::OFS_WCTRL
      |-> prdata[2:0] == 3'b111;
  endproperty
  a_lock: assert property (p_lock) else $error("watchdog unlocked");
  property p_rst; $rose(cardRstReq) |=> cardRstReq [*8]; endproperty
  a_rst: assert property (p_rst) else $error("reset request short");
  c_wirq: cover property ($rose(wdtIrq));
  c_tirq: cover property ($rose(tmrIrq));
  c_rst: cover property ($rose(cardRstReq));
endmodule : wdt_timers_sva
bind wdt_timers wdt_timers_sva i_wdt_timers_sva (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wdtIrq(wdtIrq), .tmrIrq(tmrIrq), .cardRstReq(cardRstReq));

/* wdt_timers_bench.sv */
`timescale 1ns/100ps
// Self-checking bench for the watchdog and system timer block
module wdt_timers_bench;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} wdt_note_s;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic wdtIrq, tmrIrq, cardRstReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  wdt_note_s notes[$];
  wdt_note_s n;
  int miscompares = 0, compares = 0, cycles = 0, seed = 32'h718c, p;
  wdt_timers i_wdt_timers (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdtIrq(wdtIrq),
    .tmrIrq(tmrIrq), .cardRstReq(cardRstReq));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Read results are judged here, in the order the reads were issued
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end else if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = notes.pop_front();
      compares++;
      if ((prdata & n.m) !== n.d || pslverr !== n.e) begin
        miscompares++;
        $display("Error read %h exp %h got %h", paddr, n.d, prdata);
      end
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] d, m, input logic e);
    notes.push_back({d, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Tick phase is unknown, so an expiry is accepted inside a window
  task wt(input int s, input int lo, input int hi);
    int k;
    k = 0;
    while ((s == 0 ? wdtIrq : s == 1 ? tmrIrq : cardRstReq) !== 1'b1
      && k < hi) begin
      @(posedge mclk);
      #1;
      k++;
    end
    compares++;
    if (k < lo || k >= hi) begin
      miscompares++;
      $display("Error wait %0d exp %0d..%0d got %0d", s, lo, hi, k);
    end
  endtask : wt
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b1, wdt_pkg::OFS_STATUS, 32'h73);
    rd(wdt_pkg::OFS_WCOUNT, 32'hffffff, 32'hffffff, 1'b0);
    rd(wdt_pkg::OFS_WCTRL, 32'h0, 32'h7, 1'b0);
    rd(12'h040, 32'h0, 32'hffffffff, 1'b1);
    $display("test reset done");
    apb(1'b1, wdt_pkg::OFS_WPRESET, 32'h3);
    rd(wdt_pkg::OFS_WCOUNT, 32'h3, 32'hffffff, 1'b0);
    apb(1'b1, wdt_pkg::OFS_WCTRL, 32'h1);
    repeat (300) @(posedge mclk);
    // A kick before the first expiry must restart the full period
    apb(1'b1, wdt_pkg::OFS_WCTRL, 32'h5);
    wt(0, 3 * 125 - 5, 4 * 125 + 10);
    rd(wdt_pkg::OFS_STATUS, 32'h1, 32'h3, 1'b0);
    apb(1'b1, wdt_pkg::OFS_WCTRL, 32'h0);
    apb(1'b1, wdt_pkg::OFS_STATUS, 32'h1);
    rd(wdt_pkg::OFS_STATUS, 32'h0, 32'h1, 1'b0);
    $display("test watchdog irq done");
    for (int i = 0; i < 3; i++) begin
      p = ($random(seed) & 3) + 1;
      apb(1'b1, wdt_pkg::OFS_TBASE + 12'(i * 8), 32'(p));
      apb(1'b1, wdt_pkg::OFS_TCTRL, 32'h1 << i);
      wt(1, p * 125 - 5, (p + 1) * 125 + 10);
      rd(wdt_pkg::OFS_STATUS, 32'h10 << i, 32'h70, 1'b0);
      apb(1'b1, wdt_pkg::OFS_TCTRL, 32'h0);
      apb(1'b1, wdt_pkg::OFS_STATUS, 32'h70);
    end
    apb(1'b1, wdt_pkg::OFS_TBASE, 32'h1);
    apb(1'b1, wdt_pkg::OFS_TBASE + wdt_pkg::OFS_TSTEP, 32'h1);
    apb(1'b1, wdt_pkg::OFS_TCTRL, 32'hb);
    wt(1, 3 * 125 - 5, 4 * 125 + 10);
    rd(wdt_pkg::OFS_STATUS, 32'h20, 32'h70, 1'b0);
    apb(1'b1, wdt_pkg::OFS_TCTRL, 32'h0);
    $display("test system timers done");
    apb(1'b1, wdt_pkg::OFS_WPRESET, 32'h2);
    apb(1'b1, wdt_pkg::OFS_WCTRL, 32'h3);
    apb(1'b1, wdt_pkg::OFS_WCTRL, 32'h0);
    rd(wdt_pkg::OFS_WCTRL, 32'h7, 32'h7, 1'b0);
    wt(2, 2 * 125 - 40, 3 * 125 + 30);
    repeat (10) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(wdt_pkg::OFS_STATUS, 32'h2, 32'h2, 1'b0);
    rd(wdt_pkg::OFS_WCTRL, 32'h0, 32'h7, 1'b0);
    $display("test watchdog reset done");
    summarize();
  end
endmodule : wdt_timers_bench
